// ===== tb_top.sv
// Self-checking bench for the timestamp capture unit
`timescale 1ns/1ps
module tb_top;
    logic core_clk_i = 1'b0, rst_i = 1'b1, wr = 1'b0, rd = 1'b0, fsync = 1'b0, rdy;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, v;
    logic [3:0] ls = 4'h0, fst = 4'h0;
    logic [15:0] s0, s1;
    logic [31:0] seed = 32'h2c2fa500;
    int err_count = 0, check_count = 0, cyc = 0;
    tsc_capture tsc_capture_i (.core_clk_i(core_clk_i), .rst_i(rst_i), .reg_addr_i(addr),
        .reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
        .frame_sync_i(fsync), .line_start_i(ls), .frame_start_i(fst), .captures_ready_o(rdy));
    initial begin
        forever #10 core_clk_i = ~core_clk_i;
    end
    // Run is well under 3000 cycles
    always @(posedge core_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            end_of_test();
        end
    end
    // ====
    // Helpers
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    function automatic logic [7:0] rmask(input logic [7:0] a, input logic [7:0] d);
        return a == 8'h25 ? d & 8'h7b : (a == 8'h26 ? d & 8'h1f : d);
    endfunction
    function automatic int tdiv(input int t);
        return t == 3 ? 1000 / 20 : (40 << t) / 20;
    endfunction
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        check_count++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk_i);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge core_clk_i);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk_i);
        addr <= a;
        rd <= 1'b1;
        @(posedge core_clk_i);
        rd <= 1'b0;
        @(posedge core_clk_i);
        #1 d = rdata;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        rreg(a, v);
        chk($sformatf("reg %h", a), {8'h0, e}, {8'h0, v});
    endtask
    task automatic stamp(input int p, output logic [15:0] s);
        rreg(8'h2a + 8'(2 * p), s[15:8]);
        rreg(8'h2b + 8'(2 * p), s[7:0]);
    endtask
    // Line-start capture lands on the line pulse, three edges after the wait
    task automatic ev(input int w, input logic [3:0] m);
        repeat (w) @(posedge core_clk_i);
        @(posedge core_clk_i);
        fst <= m;
        @(posedge core_clk_i);
        fst <= 4'h0;
        ls <= m;
        @(posedge core_clk_i);
        ls <= 4'h0;
    endtask
    task automatic sy(input logic l);
        @(posedge core_clk_i);
        fsync <= l;
        repeat (2) @(posedge core_clk_i);
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // ====
    // Scenarios
    initial begin
        repeat (20) @(posedge core_clk_i);
        rst_i <= 1'b0;
        for (int a = 8'h24; a <= 8'h32; a++) begin
            rchk(8'(a), 8'h00);
        end
        $display("reset values done");
        for (int i = 0; i < 8; i++) begin
            seed = lfsr(seed);
            wreg(8'h25 + 8'(i % 4), seed[7:0]);
            rchk(8'h25 + 8'(i % 4), rmask(8'h25 + 8'(i % 4), seed[7:0]));
        end
        $display("register access done");
        wreg(8'h27, 8'h00);
        wreg(8'h28, 8'h01);
        wreg(8'h26, 8'h03);
        for (int t = 0; t < 4; t++) begin
            wreg(8'h25, 8'((t << 4) | 2));
            ev(0, 4'h5);
            ev(3 * tdiv(t) - 3, 4'ha);
            stamp(0, s0);
            stamp(1, s1);
            chk("tick gap", s0 + 16'h3, s1);
            stamp(2, s1);
            chk("disabled port", 16'h0, s1);
            rchk(8'h29, 8'h13);
        end
        wreg(8'h26, 8'h13);
        @(posedge core_clk_i);
        #1 chk("ready on hold", 16'h0, {15'h0, rdy});
        ev(0, 4'h3);
        stamp(0, s1);
        chk("held stamp", s0, s1);
        rchk(8'h29, 8'h03);
        wreg(8'h26, 8'h03);
        ev(0, 4'h1);
        stamp(0, s1);
        chk("stamp moved", 16'h1, 16'(s1 != s0));
        rchk(8'h29, 8'h13);
        $display("free run and hold done");
        // Two silent rounds first, so older valid flags cannot set ready
        for (int e = 0; e < 2; e++) begin
            wreg(8'h26, 8'h01);
            wreg(8'h25, 8'((e << 6) | 1));
            repeat (2) begin
                sy(~e[0]);
                sy(e[0]);
            end
            ev(0, 4'h1);
            rchk(8'h29, 8'h01);
            sy(~e[0]);
            rchk(8'h29, 8'h10);
        end
        $display("paced rounds done");
        // Paced line start with ready as soon as both ports hold a stamp
        wreg(8'h26, 8'h03);
        wreg(8'h25, 8'h48);
        sy(1'b1);
        sy(1'b0);
        ev(0, 4'h1);
        rchk(8'h29, 8'h01);
        ev(0, 4'h2);
        rchk(8'h29, 8'h13);
        $display("ready when all ports done");
        // Free-run frame start waits for the programmed line first
        wreg(8'h28, 8'h02);
        wreg(8'h25, 8'h03);
        stamp(0, s0);
        ev(0, 4'h1);
        stamp(0, s1);
        chk("gated frame stamp", s0, s1);
        @(posedge core_clk_i);
        ls <= 4'h1;
        @(posedge core_clk_i);
        ls <= 4'h0;
        ev(0, 4'h1);
        stamp(0, s1);
        chk("frame stamp moved", 16'h1, 16'(s1 != s0));
        $display("free run frame start done");
        end_of_test();
    end
endmodule

// ===== tsc_capture.sv
// Receive-port timestamp capture unit with its register port
// Function
// - Config bit picks frame sync rising/falling edge
// - Two-bit field picks 40/80/160 ns, 1 us tick
// - Ready-all bit: ready once all enabled ports captured
// - Free-run bit: frame-sync paced or free running
// - Capture-point bit: line start or frame start
// - Hold bit freezes stamps, clears ready at once
// - Per-port enable bits gate port capture
// - Read-only ready flag, cleared by hold
// - Read-only valid flag per port
// - 16-bit line number: capture line, free-run gate
// - 16-bit stamp per port, upper/lower bytes
`timescale 1ns/1ps
module tsc_capture #(
    parameter int NUM_PORTS = tsc_pkg::NUM_PORTS,
    parameter int STAMP_W = 16
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // Register port
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    // Video timing
    input wire logic frame_sync_i,
    input wire logic [NUM_PORTS-1:0] line_start_i,
    input wire logic [NUM_PORTS-1:0] frame_start_i,
    // Status
    output logic captures_ready_o
);
    // ==========================================================
    // State
    tsc_pkg::tsc_cfg_t cfg_q, cfg_d;
    tsc_pkg::tsc_ctl_t ctl_q, ctl_d;
    logic [15:0] line_no_q, line_no_d;
    logic [STAMP_W-1:0] counter_q, counter_d;
    logic [STAMP_W-1:0] stamp_q [NUM_PORTS], stamp_d [NUM_PORTS];
    logic [15:0] line_cnt_q [NUM_PORTS], line_cnt_d [NUM_PORTS];
    logic [NUM_PORTS-1:0] gate_q, gate_d;
    logic [NUM_PORTS-1:0] valid_q, valid_d;
    logic ready_q, ready_d;
    logic fs_prev_q;
    logic armed_q, armed_d;
    logic [7:0] rdata_q, rdata_d;
    logic tick;
    logic fs_edge;
    logic all_valid;

    tsc_tick_div u_tick (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .tick_sel_i(cfg_q.tick_sel),
        .tick_o(tick)
    );

    // ==========================================================
    // Frame sync edge and round completion
    always_comb begin
        fs_edge = cfg_q.edge_sel ? (fs_prev_q & ~frame_sync_i)
                                 : (~fs_prev_q & frame_sync_i);
        all_valid = (ctl_q.enable != 4'h0) && ((valid_q & ctl_q.enable) == ctl_q.enable);
    end

    // ==========================================================
    // Register writes and reads
    always_comb begin
        cfg_d = cfg_q;
        ctl_d = ctl_q;
        line_no_d = line_no_q;
        rdata_d = rdata_q;
        if (reg_wr_i) begin
            unique case (reg_addr_i)
                tsc_pkg::CAPTURE_CONFIG_OFS: begin
                    cfg_d.edge_sel = reg_wdata_i[tsc_pkg::EDGE_SEL_BIT];
                    cfg_d.tick_sel = reg_wdata_i[tsc_pkg::TICK_SEL_LSB +: 2];
                    cfg_d.ready_all = reg_wdata_i[tsc_pkg::READY_ALL_BIT];
                    cfg_d.free_run = reg_wdata_i[tsc_pkg::FREE_RUN_BIT];
                    cfg_d.cap_point = reg_wdata_i[tsc_pkg::CAP_POINT_BIT];
                end
                tsc_pkg::CAPTURE_CONTROL_OFS: begin
                    ctl_d.hold = reg_wdata_i[tsc_pkg::HOLD_BIT];
                    ctl_d.enable = reg_wdata_i[3:0];
                end
                tsc_pkg::LINE_UPPER_OFS: line_no_d[15:8] = reg_wdata_i;
                tsc_pkg::LINE_LOWER_OFS: line_no_d[7:0] = reg_wdata_i;
                default: ;
            endcase
        end
        if (reg_rd_i) begin
            rdata_d = 8'h00;
            unique case (reg_addr_i)
                tsc_pkg::CAPTURE_CONFIG_OFS:
                    rdata_d = {1'b0, cfg_q.edge_sel, cfg_q.tick_sel, cfg_q.ready_all,
                               1'b0, cfg_q.free_run, cfg_q.cap_point};
                tsc_pkg::CAPTURE_CONTROL_OFS: rdata_d = {3'h0, ctl_q.hold, ctl_q.enable};
                tsc_pkg::LINE_UPPER_OFS: rdata_d = line_no_q[15:8];
                tsc_pkg::LINE_LOWER_OFS: rdata_d = line_no_q[7:0];
                tsc_pkg::CAPTURE_STATUS_OFS: rdata_d = {3'h0, ready_q, valid_q};
                default: begin
                    // Stamps: even offset upper byte, odd offset lower byte
                    if (reg_addr_i >= tsc_pkg::STAMP_BASE_OFS
                            && reg_addr_i <= tsc_pkg::STAMP_LAST_OFS) begin
                        logic [7:0] rel;
                        rel = reg_addr_i - tsc_pkg::STAMP_BASE_OFS;
                        rdata_d = rel[0] ? stamp_q[rel[2:1]][7:0]
                                         : stamp_q[rel[2:1]][15:8];
                    end
                end
            endcase
        end
    end

    // ==========================================================
    // Counter, capture and ready
    always_comb begin
        counter_d = tick ? counter_q + 16'h0001 : counter_q;
        stamp_d = stamp_q;
        line_cnt_d = line_cnt_q;
        gate_d = gate_q;
        valid_d = valid_q;
        ready_d = ready_q;
        armed_d = armed_q;
        // Frame sync pacing opens a fresh round on each active edge while hold is clear
        if (!cfg_q.free_run && fs_edge && !ctl_q.hold) begin
            armed_d = 1'b1;
            valid_d = '0;
            ready_d = !cfg_q.ready_all && all_valid;
        end
        for (int p = 0; p < NUM_PORTS; p++) begin
            logic evt;
            logic hit;
            evt = 1'b0;
            hit = line_start_i[p] && (line_cnt_q[p] + 16'h0001 == line_no_q);
            if (frame_start_i[p]) begin
                line_cnt_d[p] = 16'h0000;
            end else if (line_start_i[p]) begin
                line_cnt_d[p] = line_cnt_q[p] + 16'h0001;
            end
            if (hit) begin
                gate_d[p] = 1'b1;
            end
            if (cfg_q.cap_point) begin
                evt = frame_start_i[p] && (!cfg_q.free_run || gate_q[p]);
            end else begin
                evt = hit;
            end
            // Free run recaptures every event; paced mode once per round
            if (evt && ctl_q.enable[p] && !ctl_q.hold
                    && (cfg_q.free_run || (armed_q && !valid_q[p]))) begin
                stamp_d[p] = counter_q;
                valid_d[p] = 1'b1;
                gate_d[p] = 1'b0;
            end
        end
        if (cfg_q.ready_all && all_valid) begin
            ready_d = 1'b1;
        end else if (cfg_q.free_run && all_valid) begin
            ready_d = 1'b1;
        end
        // Hold drops ready and keeps it low until released
        if (ctl_q.hold || ctl_d.hold) begin
            ready_d = 1'b0;
        end
    end

    // ==========================================================
    // Registers
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cfg_q <= tsc_pkg::tsc_cfg_t'(6'h00);
            ctl_q <= tsc_pkg::tsc_ctl_t'(5'h00);
            line_no_q <= tsc_pkg::LINE_RESET;
            counter_q <= '0;
            for (int p = 0; p < NUM_PORTS; p++) begin
                stamp_q[p] <= '0;
                line_cnt_q[p] <= 16'h0000;
            end
            gate_q <= '0;
            valid_q <= '0;
            ready_q <= 1'b0;
            fs_prev_q <= 1'b0;
            armed_q <= 1'b0;
            rdata_q <= 8'h00;
        end else begin
            cfg_q <= cfg_d;
            ctl_q <= ctl_d;
            line_no_q <= line_no_d;
            counter_q <= counter_d;
            stamp_q <= stamp_d;
            line_cnt_q <= line_cnt_d;
            gate_q <= gate_d;
            valid_q <= valid_d;
            ready_q <= ready_d;
            fs_prev_q <= frame_sync_i;
            armed_q <= armed_d;
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata_o = rdata_q;
    assign captures_ready_o = ready_q;
endmodule

// ===== tsc_capture_asserts.sv
// Concurrent checks on the ports of the timestamp capture unit
`timescale 1ns/1ps
module tsc_capture_asserts #(parameter int NUM_PORTS = 4, parameter int STAMP_W = 16) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // Register port and video timing
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic frame_sync_i,
    input wire logic [NUM_PORTS-1:0] line_start_i,
    input wire logic [NUM_PORTS-1:0] frame_start_i,
    input wire logic captures_ready_o
);
    // ====
    // Shadow of the writable config and control fields
    logic [7:0] cfg_q, cfg_d, ctl_q, ctl_d;
    logic fs_q;
    wire logic act = cfg_q[6] ? (fs_q & ~frame_sync_i) : (~fs_q & frame_sync_i);
    wire logic [7:0] shd = reg_addr_i[0] ? cfg_q : ctl_q;
    always_comb begin
        cfg_d = (reg_wr_i && reg_addr_i == 8'h25) ? reg_wdata_i & 8'h7b : cfg_q;
        ctl_d = (reg_wr_i && reg_addr_i == 8'h26) ? reg_wdata_i & 8'h1f : ctl_q;
    end
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            {cfg_q, ctl_q, fs_q} <= 17'h0;
        end else begin
            {cfg_q, ctl_q, fs_q} <= {cfg_d, ctl_d, frame_sync_i};
        end
    end
    // ====
    // Properties
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    AST_REG_RW: assert property (reg_rd_i && reg_addr_i inside {8'h25, 8'h26} |=>
        reg_rdata_o == $past(shd)) else $error("config or control readback wrong");
    AST_UNMAPPED: assert property (reg_rd_i && !(reg_addr_i inside {[8'h25:8'h31]})
        |=> reg_rdata_o == 8'h00) else $error("unmapped read not zero");
    AST_RDATA_HOLD: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
        else $error("read data moved without a read");
    AST_STATUS: assert property (reg_rd_i && reg_addr_i == 8'h29 |=> reg_rdata_o[7:5] == 3'h0
        && reg_rdata_o[4] == $past(captures_ready_o)) else $error("status read wrong");
    AST_HOLD_CLEAR: assert property (reg_wr_i && reg_addr_i == 8'h26 && reg_wdata_i[4]
        |=> !captures_ready_o) else $error("hold did not clear ready");
    AST_HOLD_KEEP: assert property (ctl_q[4] |-> !captures_ready_o)
        else $error("ready high while held");
    AST_PACED_READY: assert property ($rose(captures_ready_o) && !$past(cfg_q[1]) &&
        !$past(cfg_q[3]) |-> $past(act)) else $error("paced ready without active edge");
    AST_FREE_READY: assert property ($rose(captures_ready_o) && $past(cfg_q[1] | cfg_q[3])
        |-> $past(ctl_q[3:0]) != 4'h0) else $error("ready with no port enabled");
    cover property ($rose(captures_ready_o));
    cover property (ctl_q[4] && reg_rd_i);
    cover property (act && !cfg_q[1]);
endmodule
bind tsc_capture tsc_capture_asserts #(.NUM_PORTS(NUM_PORTS), .STAMP_W(STAMP_W)) tsc_capture_asserts_i (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .frame_sync_i(frame_sync_i), .line_start_i(line_start_i), .frame_start_i(frame_start_i),
    .captures_ready_o(captures_ready_o));

// ===== tsc_pkg.sv
// Package for the receive-port timestamp capture unit: map, fields, timing
package tsc_pkg;
    // ==========================================================
    // Register offsets
    localparam logic [7:0] CAPTURE_CONFIG_OFS = 8'h25;
    localparam logic [7:0] CAPTURE_CONTROL_OFS = 8'h26;
    localparam logic [7:0] LINE_UPPER_OFS = 8'h27;
    localparam logic [7:0] LINE_LOWER_OFS = 8'h28;
    localparam logic [7:0] CAPTURE_STATUS_OFS = 8'h29;
    localparam logic [7:0] STAMP_BASE_OFS = 8'h2a;
    localparam logic [7:0] STAMP_LAST_OFS = 8'h31;

    // ==========================================================
    // Field positions
    localparam int EDGE_SEL_BIT = 6;
    localparam int TICK_SEL_LSB = 4;
    localparam int READY_ALL_BIT = 3;
    localparam int FREE_RUN_BIT = 1;
    localparam int CAP_POINT_BIT = 0;
    localparam int HOLD_BIT = 4;
    localparam int READY_FLAG_BIT = 4;
    localparam int NUM_PORTS = 4;

    // ==========================================================
    // Reset values
    localparam logic [7:0] CONFIG_RESET = 8'h00;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [15:0] LINE_RESET = 16'h0000;

    // ==========================================================
    // Timing
    localparam int CLK_PERIOD_NS = 20;
    localparam int TICK0_NS = 40;
    localparam int TICK1_NS = 80;
    localparam int TICK2_NS = 160;
    localparam int TICK3_US = 1;
    localparam int TICK0_CYC = TICK0_NS / CLK_PERIOD_NS;
    localparam int TICK1_CYC = TICK1_NS / CLK_PERIOD_NS;
    localparam int TICK2_CYC = TICK2_NS / CLK_PERIOD_NS;
    localparam int TICK3_CYC = TICK3_US * 1000 / CLK_PERIOD_NS;

    // ==========================================================
    // Carriers
    typedef struct packed {
        logic edge_sel;
        logic [1:0] tick_sel;
        logic ready_all;
        logic free_run;
        logic cap_point;
    } tsc_cfg_t;

    typedef struct packed {
        logic hold;
        logic [3:0] enable;
    } tsc_ctl_t;
endpackage

// ===== tsc_tick_div.sv
// Divider producing one enable pulse per selected timestamp tick
`timescale 1ns/1ps
module tsc_tick_div (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // Resolution select
    input wire logic [1:0] tick_sel_i,
    // Tick enable
    output logic tick_o
);
    // ==========================================================
    // Tick length lookup
    function automatic logic [5:0] tick_len(input logic [1:0] sel);
        unique case (sel)
            2'h0: tick_len = 6'(tsc_pkg::TICK0_CYC);
            2'h1: tick_len = 6'(tsc_pkg::TICK1_CYC);
            2'h2: tick_len = 6'(tsc_pkg::TICK2_CYC);
            2'h3: tick_len = 6'(tsc_pkg::TICK3_CYC);
        endcase
    endfunction

    logic [5:0] cnt_q, cnt_d;
    logic tick_q, tick_d;

    // ==========================================================
    // Count
    always_comb begin
        tick_d = 1'b0;
        cnt_d = cnt_q + 6'h01;
        // Reselecting mid-count just shortens or stretches one tick
        if (cnt_q >= tick_len(tick_sel_i) - 6'h01) begin
            cnt_d = 6'h00;
            tick_d = 1'b1;
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_q <= 6'h00;
            tick_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            tick_q <= tick_d;
        end
    end

    assign tick_o = tick_q;
endmodule
